// ==== gpdr_top.sv ====
// Port 2 data register: direction and input level of five pins, drive of four (pin 2.4 has none).
// Assumes an APB master on pclk and pin pads resolved outside the block.
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - bit 30 sets pin 2.6 direction
// - bit 29 sets pin 2.5 direction, diagnostic write
// - bit 28 sets pin 2.4 direction, diagnostic readback
// - bits 25, 24 set pins 2.1, 2.0 direction
// - bits 22, 21 drive pins 2.6, 2.5
// - bits 17, 16 drive pins 2.1, 2.0
// - bits 6..4 read pin levels, unwritable
// - bits 1, 0 read pin levels, unwritable
// - one 32-bit register at fixed address
module gpdr_top (
  input wire logic pclk, // System clock, 200 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic pce, // Clock enable, freezes all state
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high for write
  input wire logic [31:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire gpdr_pkg::gpdr_pins_s pin_in, // Pin levels
  output var gpdr_pkg::gpdr_pins_s pin_out, // Pin drive values
  output var gpdr_pkg::gpdr_pins_s pin_oe, // Pin drive enables
  output logic hv_diag_write_en, // Diagnostic write path open
  output logic hv_diag_read_en // Diagnostic readback path open
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  gpdr_pkg::gpdr_pins_s dir_q; // Direction bits
  gpdr_pkg::gpdr_pins_s out_q; // Drive bits, p4 held at zero
  gpdr_pkg::gpdr_pins_s samp; // Sampled pin levels
  logic [31:0] prdata_q; // Read data register
  logic pready_q; // Ready register
  logic pslverr_q; // Error register
  logic diag_wr_q; // Diagnostic write path flag
  logic diag_rd_q; // Diagnostic readback path flag
  logic addr_hit; // Address matches the register
  logic setup_ph; // Setup cycle of a transfer
  logic acc_wr; // Write taking effect this edge
  logic lane_dir; // Direction lane written
  logic lane_out; // Drive lane written
  logic [31:0] rd_word; // Assembled read value

  ////////////////////////////////////////////////////////////////////////////
  // Input sampling register
  gpdr_pin_sample u_samp (
    .pclk(pclk),
    .presetn(presetn),
    .pce(pce),
    .pin_in(pin_in),
    .samp_q(samp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  // Fixed register address
  // full address compare
  assign addr_hit = (paddr == gpdr_pkg::GPDR_DATA_ADDR);
  assign setup_ph = psel && !penable;
  // Write lands on the ready edge only
  assign acc_wr = pce && psel && penable && pready_q && pwrite && addr_hit;
  assign lane_dir = acc_wr && pstrb[gpdr_pkg::LANE_DIR];
  assign lane_out = acc_wr && pstrb[gpdr_pkg::LANE_OUT];

  ////////////////////////////////////////////////////////////////////////////
  // Read word assembly
  // reserved and absent bits zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_word[gpdr_pkg::DIR_P6] = dir_q.p6;
    rd_word[gpdr_pkg::DIR_P5] = dir_q.p5;
    rd_word[gpdr_pkg::DIR_P4] = dir_q.p4;
    rd_word[gpdr_pkg::DIR_P1] = dir_q.p1;
    rd_word[gpdr_pkg::DIR_P0] = dir_q.p0;
    rd_word[gpdr_pkg::OUT_P6] = out_q.p6;
    rd_word[gpdr_pkg::OUT_P5] = out_q.p5;
    rd_word[gpdr_pkg::OUT_P1] = out_q.p1;
    rd_word[gpdr_pkg::OUT_P0] = out_q.p0;
    rd_word[gpdr_pkg::IN_P6] = samp.p6;
    rd_word[gpdr_pkg::IN_P5] = samp.p5;
    rd_word[gpdr_pkg::IN_P4] = samp.p4;
    rd_word[gpdr_pkg::IN_P1] = samp.p1;
    rd_word[gpdr_pkg::IN_P0] = samp.p0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: ready one cycle after setup, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= gpdr_pkg::GPDR_RD_ZERO;
    end else if (pce) begin
      pready_q <= setup_ph;
      // Unmapped address answers with error
      pslverr_q <= setup_ph && !addr_hit;
      // Read data latched at the end of setup
      if (setup_ph && !pwrite && addr_hit) begin
        prdata_q <= rd_word;
      end else begin
        prdata_q <= gpdr_pkg::GPDR_RD_ZERO;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direction bits, top byte lane
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= '{gpdr_pkg::DIR_RST, gpdr_pkg::DIR_RST, gpdr_pkg::DIR_RST,
                 gpdr_pkg::DIR_RST, gpdr_pkg::DIR_RST};
    end else if (lane_dir) begin
      dir_q.p6 <= pwdata[gpdr_pkg::DIR_P6];
      dir_q.p5 <= pwdata[gpdr_pkg::DIR_P5];
      dir_q.p4 <= pwdata[gpdr_pkg::DIR_P4];
      dir_q.p1 <= pwdata[gpdr_pkg::DIR_P1];
      dir_q.p0 <= pwdata[gpdr_pkg::DIR_P0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive bits, third byte lane; pin 2.4 has none and drives low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= '{gpdr_pkg::OUT_RST, gpdr_pkg::OUT_RST, gpdr_pkg::OUT_RST,
                 gpdr_pkg::OUT_RST, gpdr_pkg::OUT_RST};
    end else if (lane_out) begin
      out_q.p6 <= pwdata[gpdr_pkg::OUT_P6];
      out_q.p5 <= pwdata[gpdr_pkg::OUT_P5];
      out_q.p1 <= pwdata[gpdr_pkg::OUT_P1];
      out_q.p0 <= pwdata[gpdr_pkg::OUT_P0];
      out_q.p4 <= gpdr_pkg::OUT_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Diagnostic write flag follows the pin 2.5 direction, readback flag the inverse of pin 2.4 direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diag_wr_q <= gpdr_pkg::DIR_RST;
      diag_rd_q <= !gpdr_pkg::DIR_RST;
    end else if (lane_dir) begin
      diag_wr_q <= pwdata[gpdr_pkg::DIR_P5];
      diag_rd_q <= !pwdata[gpdr_pkg::DIR_P4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pin_oe = dir_q;
  assign pin_out = out_q;
  assign hv_diag_write_en = diag_wr_q;
  assign hv_diag_read_en = diag_rd_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_DIR_P6: assert property (
    lane_dir |=> pin_oe.p6 == $past(pwdata[gpdr_pkg::DIR_P6]))
    else $error("pin 2.6 direction not taken from write");

  AST_DIR_P5_DIAG: assert property (
    lane_dir |=> (pin_oe.p5 == $past(pwdata[gpdr_pkg::DIR_P5]))
      && (hv_diag_write_en == pin_oe.p5))
    else $error("pin 2.5 direction or diagnostic write flag wrong");

  AST_DIR_P4_DIAG: assert property (
    lane_dir |=> (pin_oe.p4 == $past(pwdata[gpdr_pkg::DIR_P4]))
      && (hv_diag_read_en != pin_oe.p4))
    else $error("pin 2.4 direction or diagnostic readback flag wrong");

  AST_DIR_P1_P0: assert property (
    lane_dir |=> {pin_oe.p1, pin_oe.p0}
      == {$past(pwdata[gpdr_pkg::DIR_P1]), $past(pwdata[gpdr_pkg::DIR_P0])})
    else $error("pins 2.1, 2.0 direction not taken from write");

  AST_OUT_P6_P5: assert property (
    lane_out |=> {pin_out.p6, pin_out.p5}
      == {$past(pwdata[gpdr_pkg::OUT_P6]), $past(pwdata[gpdr_pkg::OUT_P5])})
    else $error("pins 2.6, 2.5 drive not taken from write");

  AST_OUT_P1_P0: assert property (
    (lane_out |=> {pin_out.p1, pin_out.p0}
      == {$past(pwdata[gpdr_pkg::OUT_P1]), $past(pwdata[gpdr_pkg::OUT_P0])})
    and (!lane_out |=> $stable(pin_out)))
    else $error("pins 2.1, 2.0 drive wrong or changed without write");

  // Clock enable low holds the register and the bus answer
  AST_CE_FREEZE: assert property (
    !pce |=> $stable(pin_oe) && $stable(pin_out) && $stable(pready) && $stable(prdata))
    else $error("state moved while clock enable low");

  AST_IN_UPPER: assert property (
    (pce && setup_ph && !pwrite && addr_hit) |=> pready
      && (prdata[6:4] == {$past(samp.p6), $past(samp.p5), $past(samp.p4)}))
    else $error("upper pin levels not returned on read");

  AST_IN_LOWER: assert property (
    (pce && setup_ph && !pwrite && addr_hit) |=>
      (prdata[1:0] == {$past(samp.p1), $past(samp.p0)})
      && (pin_out.p4 == 1'b0))
    else $error("lower pin levels not returned on read");

  AST_RSVD_ZERO: assert property (
    (pready && !pwrite) |-> ((prdata & ~gpdr_pkg::GPDR_LIVE_MASK) == 32'h0000_0000))
    else $error("reserved read bits not zero");

  AST_UNMAPPED: assert property (
    (pce && setup_ph && !addr_hit) |=> pready && pslverr && (prdata == 32'h0000_0000))
    else $error("unmapped address not refused");

  COV_WRITE: cover property (lane_dir && lane_out);
  COV_READ: cover property (pce && setup_ph && !pwrite && addr_hit ##1 pready);
  COV_ERR: cover property (pslverr);
  COV_B2B: cover property (acc_wr ##1 setup_ph ##1 pready);

endmodule

`default_nettype wire

// ==== gpdr_pkg.sv ====
// Constants and types shared by the port 2 data register block.
// Assumes a 32-bit APB host and five port 2 pins sampled on pclk.
package gpdr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Address map
  localparam logic [31:0] GPDR_DATA_ADDR = 32'hffff0d40; // Data register byte address
  localparam logic [31:0] GPDR_RD_ZERO = 32'h0000_0000; // Answer to unmapped reads

  ////////////////////////////////////////////////////////////////////////////
  // Field positions inside the data word
  localparam int unsigned DIR_P6 = 30; // Direction, pin 2.6
  localparam int unsigned DIR_P5 = 29; // Direction, pin 2.5
  localparam int unsigned DIR_P4 = 28; // Direction, pin 2.4
  localparam int unsigned DIR_P1 = 25; // Direction, pin 2.1
  localparam int unsigned DIR_P0 = 24; // Direction, pin 2.0
  localparam int unsigned OUT_P6 = 22; // Drive value, pin 2.6
  localparam int unsigned OUT_P5 = 21; // Drive value, pin 2.5
  localparam int unsigned OUT_P1 = 17; // Drive value, pin 2.1
  localparam int unsigned OUT_P0 = 16; // Drive value, pin 2.0
  localparam int unsigned IN_P6 = 6; // Pin level, pin 2.6
  localparam int unsigned IN_P5 = 5; // Pin level, pin 2.5
  localparam int unsigned IN_P4 = 4; // Pin level, pin 2.4
  localparam int unsigned IN_P1 = 1; // Pin level, pin 2.1
  localparam int unsigned IN_P0 = 0; // Pin level, pin 2.0

  // Byte lanes holding the writable fields
  localparam int unsigned LANE_DIR = 3; // Direction bits 31..24
  localparam int unsigned LANE_OUT = 2; // Drive bits 23..16

  // Bits that carry meaning; all others read zero
  localparam logic [31:0] GPDR_LIVE_MASK = 32'h7363_0073;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic DIR_RST = 1'b0; // All pins inputs
  localparam logic OUT_RST = 1'b0; // Drive values low
  localparam logic IN_RST = 1'b0; // Sampled levels before first edge

  ////////////////////////////////////////////////////////////////////////////
  // One bit per port 2 pin
  typedef struct packed {
    logic p6;
    logic p5;
    logic p4;
    logic p1;
    logic p0;
  } gpdr_pins_s;

endpackage

// ==== gpdr_pin_sample.sv ====
// Input sampling register for the five port 2 pins.
// Assumes the pin levels are already synchronous to pclk.
`timescale 1ns/10ps
`default_nettype none

module gpdr_pin_sample (
  input wire logic pclk, // System clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic pce, // Clock enable, freezes the sample
  input wire gpdr_pkg::gpdr_pins_s pin_in, // Pin levels
  output var gpdr_pkg::gpdr_pins_s samp_q // Registered pin levels
);

  ////////////////////////////////////////////////////////////////////////////
  // Capture every pin once per enabled edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_q <= '{gpdr_pkg::IN_RST, gpdr_pkg::IN_RST, gpdr_pkg::IN_RST,
                  gpdr_pkg::IN_RST, gpdr_pkg::IN_RST};
    end else if (pce) begin
      samp_q <= pin_in;
    end
  end

endmodule

`default_nettype wire

// ==== gpdr_pad_model.sv ====
// Pad model for the five port 2 pins, standing outside the block.
// Assumes the bench supplies the level that outside circuits put on each pin.
`timescale 1ns/10ps
`default_nettype none

module gpdr_pad_model (
  input wire gpdr_pkg::gpdr_pins_s pin_out, // Drive values from block
  input wire gpdr_pkg::gpdr_pins_s pin_oe, // Drive enables from block
  input wire gpdr_pkg::gpdr_pins_s ext_lvl, // Level from outside circuits
  output var gpdr_pkg::gpdr_pins_s pin_in // Resolved pin level
);
  ////////////////////////////////////////////////////////////////////////////
  // driven pins win
  always_comb begin
    pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
  end
endmodule

`default_nettype wire

// ==== gpio_port2_data_register_test.sv ====
// Self-checking bench for the port 2 data register.
// Assumes an APB master here and the pad model on the pin side.
`timescale 1ns/10ps
`default_nettype none

module gpio_port2_data_register_test;
  logic pclk = 1'h0; // 200 MHz clock
  logic presetn = 1'h0; // Reset, active low
  logic pce = 1'h1; // Clock enable
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic hv_wr;
  logic hv_rd;
  gpdr_pkg::gpdr_pins_s pin_in, pin_out, pin_oe;
  gpdr_pkg::gpdr_pins_s ext_lvl = '0; // Outside pin levels
  logic [4:0] dir_m = 5'h0; // Expected directions p6,p5,p4,p1,p0
  logic [4:0] out_m = 5'h0; // Expected drive values
  integer seed = 14750;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [31:0] w;

  // Clock
  always #2.5 pclk = ~pclk;

  gpdr_top u_gpdr_top (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .hv_diag_write_en(hv_wr),
    .hv_diag_read_en(hv_rd));
  gpdr_pad_model u_gpdr_pad_model (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_lvl(ext_lvl), .pin_in(pin_in));

  ////////////////////////////////////////////////////////////////////////////
  // Expected register word from model state
  function automatic logic [31:0] exp_word();
    logic [4:0] lv;
    lv = (dir_m & out_m) | (~dir_m & ext_lvl);
    return {1'h0, dir_m[4:2], 2'h0, dir_m[1:0], 1'h0, out_m[4:3], 3'h0, out_m[1:0],
      9'h000, lv[4:2], 2'h0, lv[1:0]};
  endfunction

  // Word compare
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t word got %h exp %h", $time, got, exp);
    end
  endtask

  // Pin group compare
  task automatic chk_pins(input logic [4:0] got, input logic [4:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t pins got %h exp %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic end_sim();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One APB transfer, then checks of answer and pins
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
      input logic [3:0] s);
    logic [31:0] r;
    logic e;
    logic hit;
    hit = (a === gpdr_pkg::GPDR_DATA_ADDR);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    chk_word({31'h0, e}, {31'h0, ~hit});
    // Write updates model
    if (wr && hit && s[3]) dir_m = {wd[30], wd[29], wd[28], wd[25], wd[24]};
    if (wr && hit && s[2]) out_m = {wd[22], wd[21], 1'h0, wd[17], wd[16]};
    // Read data checked against model
    if (!wr) chk_word(r, hit ? exp_word() : 32'h0);
    @(posedge pclk);
    @(posedge pclk);
    chk_pins(pin_oe, dir_m);
    chk_pins(pin_out, out_m);
    chk_word({30'h0, hv_wr, hv_rd}, {30'h0, dir_m[3], ~dir_m[2]});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    ext_lvl <= 5'h15;
    @(posedge pclk);
    // Reset state read back
    xfer(1'h0, gpdr_pkg::GPDR_DATA_ADDR, 32'h0, 4'hf);
    // All ones: reserved and input bits ignore writes
    xfer(1'h1, gpdr_pkg::GPDR_DATA_ADDR, 32'hffffffff, 4'hf);
    xfer(1'h0, gpdr_pkg::GPDR_DATA_ADDR, 32'h0, 4'hf);
    // Unmapped address refused
    xfer(1'h1, gpdr_pkg::GPDR_DATA_ADDR + 32'h4, 32'h0, 4'hf);
    xfer(1'h0, gpdr_pkg::GPDR_DATA_ADDR + 32'h4, 32'h0, 4'hf);
    // Random traffic with writes that keep reserved bits zero
    repeat (60) begin
      ext_lvl <= 5'($random(seed));
      w = $random(seed) & 32'h7363_0000;
      xfer(1'h1, gpdr_pkg::GPDR_DATA_ADDR, w, 4'($random(seed)));
      xfer(1'h0, gpdr_pkg::GPDR_DATA_ADDR, 32'h0, 4'hf);
    end
    // Clock enable low freezes the block while outside levels move
    pce <= 1'h0;
    ext_lvl <= ~ext_lvl;
    repeat (4) @(posedge pclk);
    chk_pins(pin_out, out_m);
    pce <= 1'h1;
    @(posedge pclk);
    // Second reset in mid-run clears outputs but sets the readback flag
    presetn <= 1'h0;
    dir_m = 5'h0;
    out_m = 5'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    @(posedge pclk);
    xfer(1'h0, gpdr_pkg::GPDR_DATA_ADDR, 32'h0, 4'hf);
    end_sim();
  end

  // Watchdog
  initial begin
    #20000;
    error_cnt++;
    end_sim();
  end
endmodule

`default_nettype wire
